// ===== core/emas_pkg.sv
// Package: constants and types for the address and strap pin block
package emas_pkg;
	localparam int EMAS_AW         = 16;
	localparam int EMAS_STRAP_W    = 3;
	localparam int EMAS_SRC_BIT    = 2;
	localparam int EMAS_FREQ_HI    = 1;
	localparam int EMAS_FREQ_LO    = 0;
	localparam int EMAS_REG_AW     = 2;
	localparam int EMAS_REG_DW     = 8;
	// Register indexes
	localparam logic [1:0] EMAS_REG_CTRL   = 2'h0;
	localparam logic [1:0] EMAS_REG_STATUS = 2'h1;
	localparam logic [1:0] EMAS_REG_PINS   = 2'h2;
	// Control register fields
	localparam int EMAS_CTRL_IDLE  = 0;
	localparam int EMAS_CTRL_SLEEP = 1;
	localparam logic [7:0] EMAS_CTRL_RST = 8'h00;
	// Strap decode
	localparam logic       EMAS_SRC_XTAL  = 1'h0;
	localparam logic       EMAS_SRC_EXT   = 1'h1;
	localparam logic [1:0] EMAS_FREQ_24   = 2'h0;
	localparam logic [1:0] EMAS_FREQ_48   = 2'h3;
	localparam logic [2:0] EMAS_STRAP_RST = 3'h0;

	typedef enum logic [1:0] {
		EMAS_CLK_XTAL24,
		EMAS_CLK_EXT24,
		EMAS_CLK_EXT48,
		EMAS_CLK_BAD
	} emas_clk_mode_e;

	typedef logic [EMAS_AW-1:0] emas_addr_t;
endpackage

// ===== core/emas_strap_if.sv
// Interface: strap capture signals between top and latch module
`timescale 1ns/1ns
interface emas_strap_if;
	logic       in_reset;
	logic [2:0] pin_sync;
	logic [2:0] strap;
	logic       captured;
	modport top   (output in_reset, output pin_sync,
	               input strap, input captured);
	modport latch (input in_reset, input pin_sync,
	               output strap, output captured);
endinterface

// ===== core/emas_strap_latch.sv
// Strap latch: holds the three straps sampled at reset release
`timescale 1ns/1ns
module emas_strap_latch
	import emas_pkg::*;
(
	// Clock and reset
	input  wire logic   i_clk,
	input  wire logic   i_rst,
	// Strap signals
	emas_strap_if.latch sif
);
	import emas_pkg::*;

	typedef struct packed {
		logic [2:0] strap;
		logic       captured;
	} emas_latch_s;

	emas_latch_s st_q;
	emas_latch_s st_d;

	always_comb begin
		st_d = st_q;
		if (sif.in_reset) begin
			st_d.strap    = sif.pin_sync;
			st_d.captured = 1'b0;
		end else begin
			st_d.captured = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_q <= '{strap: EMAS_STRAP_RST, captured: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign sif.strap    = st_q.strap;
	assign sif.captured = st_q.captured;

	a_strap_hold: assert property (@(posedge i_clk)
		disable iff (i_rst)
		(!sif.in_reset && $past(!sif.in_reset))
		|-> $stable(st_q.strap))
		else $error("strap changed outside reset");
endmodule // emas_strap_latch

// ===== core/emas_addr_pins.sv
// Top: external memory address pins with reset-time clock straps
`timescale 1ns/1ns
module emas_addr_pins
	import emas_pkg::*;
(
	// Clock and chip reset
	input  wire logic                    I_CLK,
	input  wire logic                    I_RST,
	input  wire logic                    I_CHIP_RESET_N,
	// Address from the core and external interrupt two
	input  wire emas_pkg::emas_addr_t    I_CORE_ADDR,
	input  wire logic                    I_EXT_INTERRUPT_TWO,
	// Register port
	input  wire logic [1:0]              I_REG_ADDR,
	input  wire logic [7:0]              I_REG_WDATA,
	input  wire logic                    I_REG_WR,
	input  wire logic                    I_REG_RD,
	output logic [7:0]                   O_REG_RDATA,
	// Address pins
	input  wire logic [2:0]              I_EXT_MEM_ADDR,
	output emas_pkg::emas_addr_t         O_EXT_MEM_ADDR,
	output logic [2:0]                   O_EXT_MEM_ADDR_OE,
	output logic [2:0]                   O_PULL_DOWN_EN,
	// Latched clock configuration
	output logic                         O_CLOCK_SOURCE_STRAP,
	output logic [1:0]                   O_FREQ_STRAP,
	output emas_pkg::emas_clk_mode_e     O_CLK_MODE
);
	import emas_pkg::*;

	default clocking cb_main @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	////////////////////////////////////////////////////////////////////////
	// How it works
	// - Address bits 15 to 3 are always driven from the core address.
	// - In reset bit 2 is the clock-source strap input with pull-down on.
	// - At reset release bit 2 is latched, pull-down off, address resumes.
	// - Source strap 0 means 24MHz crystal, 1 means external clock.
	// - With source strap 1, bit 2 floats when idle, sleep, no int two.
	// - With source strap 0, bit 2 is always driven outside reset.
	// - In reset bits 1 and 0 are frequency straps with pull-downs on.
	// - At reset release bits 1 and 0 are latched, pull-downs off.
	// - With source strap 1, frequency straps 00 give 24MHz, 11 give 48MHz, others reserved.
	// - A bit 1 or 0 latched high floats when idle, sleep, no int two.
	// - A bit 1 or 0 latched low is always driven outside reset.
	////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [1:0]     rst_sync;
		logic [2:0]     pin_meta;
		logic [2:0]     pin_sync;
		logic [7:0]     ctrl;
		logic [7:0]     rdata;
		emas_addr_t     addr;
		logic [2:0]     oe;
		logic [2:0]     pd;
		logic           src;
		logic [1:0]     freq;
		emas_clk_mode_e mode;
	} emas_top_s;

	emas_top_s st_q;
	emas_top_s st_d;

	emas_strap_if sif ();

	logic in_reset;
	logic quiet;

	assign in_reset     = !st_q.rst_sync[1];
	assign sif.in_reset = in_reset;
	assign sif.pin_sync = st_q.pin_sync;

	emas_strap_latch u_latch (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.sif   (sif)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_d          = st_q;
		quiet         = st_q.ctrl[EMAS_CTRL_IDLE] && !I_EXT_INTERRUPT_TWO
		                && st_q.ctrl[EMAS_CTRL_SLEEP];
		st_d.rst_sync = {st_q.rst_sync[0], I_CHIP_RESET_N};
		st_d.pin_meta = I_EXT_MEM_ADDR;
		st_d.pin_sync = st_q.pin_meta;
		// Register port
		if (I_REG_WR && I_REG_ADDR == EMAS_REG_CTRL) begin
			st_d.ctrl = I_REG_WDATA;
		end
		if (I_REG_RD) begin
			case (I_REG_ADDR)
			EMAS_REG_CTRL: begin
				st_d.rdata = st_q.ctrl;
			end
			EMAS_REG_STATUS: begin
				st_d.rdata = {3'h0, st_q.mode, sif.strap};
			end
			EMAS_REG_PINS: begin
				st_d.rdata = {2'h0, st_q.pd, st_q.oe};
			end
			default: begin
				st_d.rdata = 8'h00;
			end
			endcase
		end else begin
			st_d.rdata = 8'h00;
		end
		st_d.addr = I_CORE_ADDR;
		if (in_reset) begin
			st_d.oe = 3'h0;
			st_d.pd = 3'h7;
		end else begin
			st_d.pd = 3'h0;
			for (int b = 0; b < EMAS_STRAP_W; b++) begin
				st_d.oe[b] = !(sif.strap[b] && quiet);
			end
		end
		st_d.src  = sif.strap[EMAS_SRC_BIT];
		st_d.freq = sif.strap[EMAS_FREQ_HI:EMAS_FREQ_LO];
		if (sif.strap[EMAS_SRC_BIT] == EMAS_SRC_XTAL) begin
			st_d.mode = EMAS_CLK_XTAL24;
		end else begin
			case (sif.strap[EMAS_FREQ_HI:EMAS_FREQ_LO])
			EMAS_FREQ_24: begin
				st_d.mode = EMAS_CLK_EXT24;
			end
			EMAS_FREQ_48: begin
				st_d.mode = EMAS_CLK_EXT48;
			end
			default: begin
				st_d.mode = EMAS_CLK_BAD;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			st_q <= '{rst_sync: 2'h0,
			          pin_meta: 3'h0,
			          pin_sync: 3'h0,
			          ctrl:     EMAS_CTRL_RST,
			          rdata:    8'h00,
			          addr:     '0,
			          oe:       3'h0,
			          pd:       3'h7,
			          src:      1'b0,
			          freq:     2'h0,
			          mode:     EMAS_CLK_XTAL24};
		end else begin
			st_q <= st_d;
		end
	end

	assign O_REG_RDATA          = st_q.rdata;
	assign O_EXT_MEM_ADDR       = st_q.addr;
	assign O_EXT_MEM_ADDR_OE    = st_q.oe;
	assign O_PULL_DOWN_EN       = st_q.pd;
	assign O_CLOCK_SOURCE_STRAP = st_q.src;
	assign O_FREQ_STRAP         = st_q.freq;
	assign O_CLK_MODE           = st_q.mode;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_reset_sync: assert property (!I_CHIP_RESET_N |=>
		##1 in_reset)
		else $error("chip reset not seen in two cycles");
	a_pd_in_reset: assert property (in_reset |=>
		O_PULL_DOWN_EN == 3'h7 && O_EXT_MEM_ADDR_OE == 3'h0)
		else $error("pins not released to pull-downs in reset");
	a_pd_release: assert property (!in_reset |=>
		O_PULL_DOWN_EN == 3'h0)
		else $error("pull-down left on after reset");
	a_upper_addr: assert property (1'b1 |=>
		O_EXT_MEM_ADDR == $past(I_CORE_ADDR))
		else $error("address not following core");
	a_src_float: assert property (
		(!in_reset && sif.strap[EMAS_SRC_BIT] && quiet)
		|=> !O_EXT_MEM_ADDR_OE[EMAS_SRC_BIT])
		else $error("bit two not floated");
	a_src_wake: assert property (
		(!in_reset && !quiet)
		|=> O_EXT_MEM_ADDR_OE[EMAS_SRC_BIT])
		else $error("bit two floated while awake");
	a_src_drive: assert property (
		(!in_reset && !sif.strap[EMAS_SRC_BIT])
		|=> O_EXT_MEM_ADDR_OE[EMAS_SRC_BIT])
		else $error("bit two not driven");
	a_freq_float: assert property ((!in_reset && quiet) |=>
		O_EXT_MEM_ADDR_OE[1:0] == ~$past(sif.strap[1:0]))
		else $error("frequency pins not floated");
	a_freq_drive: assert property ((!in_reset && !quiet) |=>
		O_EXT_MEM_ADDR_OE[1:0] == 2'h3)
		else $error("frequency pins not driven");

	for (genvar g = 0; g < EMAS_STRAP_W; g++) begin : g_pin_chk
		a_pin_low_drive: assert property (
			(!in_reset && !sif.strap[g]) |=> O_EXT_MEM_ADDR_OE[g])
			else $error("low strap pin not driven");
		a_pin_high_float: assert property (
			(!in_reset && sif.strap[g] && quiet)
			|=> !O_EXT_MEM_ADDR_OE[g])
			else $error("high strap pin not floated");
	end

	a_src_out: assert property (1'b1 |=>
		O_CLOCK_SOURCE_STRAP == $past(sif.strap[EMAS_SRC_BIT]))
		else $error("source strap output wrong");
	a_freq_out: assert property (1'b1 |=>
		O_FREQ_STRAP == $past(sif.strap[EMAS_FREQ_HI:EMAS_FREQ_LO]))
		else $error("frequency strap output wrong");
	a_mode_decode: assert property ((sif.strap == 3'h7) |=>
		O_CLK_MODE == EMAS_CLK_EXT48)
		else $error("48MHz mode not decoded");
	a_mode_ext24: assert property (
		(sif.strap == {EMAS_SRC_EXT, EMAS_FREQ_24})
		|=> O_CLK_MODE == EMAS_CLK_EXT24)
		else $error("external 24MHz mode not decoded");
	a_mode_bad: assert property (
		(sif.strap[EMAS_SRC_BIT] && ^sif.strap[1:0])
		|=> O_CLK_MODE == EMAS_CLK_BAD)
		else $error("reserved pattern not flagged");
	a_mode_xtal: assert property (!sif.strap[2] |=>
		O_CLK_MODE == EMAS_CLK_XTAL24)
		else $error("crystal mode not decoded");
	a_latch_value: assert property ((in_reset ##1 !in_reset) |->
		sif.strap == $past(st_q.pin_sync))
		else $error("strap not latched at release");

	a_rd_ctrl: assert property (
		(I_REG_RD && I_REG_ADDR == EMAS_REG_CTRL)
		|=> O_REG_RDATA == $past(st_q.ctrl))
		else $error("control read wrong");
	a_rd_idle: assert property (!I_REG_RD |=> O_REG_RDATA == 8'h00)
		else $error("read data not cleared");
	a_ctrl_write: assert property (
		(I_REG_WR && I_REG_ADDR == EMAS_REG_CTRL)
		|=> st_q.ctrl == $past(I_REG_WDATA))
		else $error("control write lost");
	a_ctrl_refuse: assert property (
		(!I_REG_WR || I_REG_ADDR != EMAS_REG_CTRL)
		|=> $stable(st_q.ctrl))
		else $error("control changed without write");

	c_release: cover property (@(posedge I_CLK) in_reset ##1 !in_reset);
	c_float: cover property (@(posedge I_CLK) O_EXT_MEM_ADDR_OE == 3'h0
		&& !in_reset);
	c_ext48: cover property (@(posedge I_CLK) O_CLK_MODE == EMAS_CLK_EXT48);
	c_reg_rd: cover property (@(posedge I_CLK) I_REG_RD
		&& I_REG_ADDR == EMAS_REG_STATUS);
endmodule // emas_addr_pins

// ===== verif/emas_mem_model.sv
// Model of the board straps and external memory on address pins 2:0
`timescale 1ns/1ns
module emas_mem_model (
	// Board straps and design pins
	input  wire logic [2:0] i_strap,
	input  wire logic [2:0] i_addr,
	input  wire logic [2:0] i_oe,
	// Pad levels
	output logic [2:0]      o_pad
);
	// Driven bit follows design, floated bit settles to its strap resistor
	always_comb o_pad = (i_oe & i_addr) | (~i_oe & i_strap);
endmodule // emas_mem_model

// ===== verif/testbench.sv
// Testbench: strap capture, pin tri-state and register checks
`timescale 1ns/1ns
module testbench;
	import emas_pkg::*;
	logic           clk, rst, chip_n, ext_interrupt_two, wr, rd, src;
	logic [1:0]     radr, em, fq;
	logic [7:0]     wdat, rdat, v;
	emas_addr_t     core, mem;
	logic [2:0]     strap, pad, oe, pd;
	emas_clk_mode_e mode;
	int             fail_count, checks;
	logic [2:0]     cases [5] = '{3'h0, 3'h4, 3'h7, 3'h5, 3'h3};

	emas_addr_pins u_emas_addr_pins (.I_CLK(clk), .I_RST(rst),
		.I_CHIP_RESET_N(chip_n), .I_CORE_ADDR(core),
		.I_EXT_INTERRUPT_TWO(ext_interrupt_two), .I_REG_ADDR(radr), .I_REG_WDATA(wdat),
		.I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat),
		.I_EXT_MEM_ADDR(pad), .O_EXT_MEM_ADDR(mem), .O_EXT_MEM_ADDR_OE(oe),
		.O_PULL_DOWN_EN(pd), .O_CLOCK_SOURCE_STRAP(src),
		.O_FREQ_STRAP(fq), .O_CLK_MODE(mode));
	emas_mem_model u_emas_mem_model (.i_strap(strap), .i_addr(mem[2:0]),
		.i_oe(oe), .o_pad(pad));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		radr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		radr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic give_verdict;
		$display("mismatches %0d checks %0d", fail_count, checks);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#300000;
		fail_count++;
		give_verdict();
	end

	initial begin
		{rst, chip_n, ext_interrupt_two, wr, rd, radr, wdat, core, strap} = '0;
		rst = 1'b1;
		fail_count = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (cases[i]) begin
			em = !cases[i][2] ? EMAS_CLK_XTAL24 :
				cases[i][1:0] == EMAS_FREQ_24 ? EMAS_CLK_EXT24 :
				cases[i][1:0] == EMAS_FREQ_48 ? EMAS_CLK_EXT48 : EMAS_CLK_BAD;
			@(posedge clk);
			strap <= cases[i];
			chip_n <= 1'b0;
			repeat (4) @(posedge clk);
			#1 check(pd, 3'h7);
			check(oe, 3'h0);
			@(posedge clk);
			chip_n <= 1'b1;
			core <= {13'h15A3, ~cases[i]};
			repeat (5) @(posedge clk);
			#1 check({src, fq}, cases[i]);
			check(pd, 3'h0);
			check(oe, 3'h7);
			check(mem, core);
			check(mode, em);
			reg_rd(EMAS_REG_STATUS, v);
			check(v, {3'h0, em, cases[i]});
			reg_wr(EMAS_REG_CTRL, 8'h03);
			repeat (3) @(posedge clk);
			#1 check(oe, 3'(~cases[i]));
			check(mem[15:3], core[15:3]);
			reg_rd(EMAS_REG_CTRL, v);
			check(v, 8'h03);
			@(posedge clk);
			ext_interrupt_two <= 1'b1;
			repeat (3) @(posedge clk);
			#1 check(oe, 3'h7);
			reg_rd(EMAS_REG_PINS, v);
			check(v, 8'h07);
			@(posedge clk);
			ext_interrupt_two <= 1'b0;
			reg_wr(EMAS_REG_CTRL, 8'h01);
			repeat (3) @(posedge clk);
			#1 check(oe, 3'h7);
			check({src, fq}, cases[i]);
			reg_wr(EMAS_REG_CTRL, 8'h00);
		end
		reg_rd(2'h3, v);
		check(v, 8'h00);
		give_verdict();
	end
endmodule // testbench
